// File: rtl/rsve_defs.svh
// Constants for the run-time variable Reed-Solomon encoder.
`ifndef RSVE_DEFS_SVH
`define RSVE_DEFS_SVH

`define RSVE_SYM_W       8
`define RSVE_SYM_W_MIN   4
`define RSVE_SYM_W_MAX   10
`define RSVE_N_W         8
`define RSVE_R_W         6
`define RSVE_STEP_W      9
`define RSVE_N_MAX       8'hFF
`define RSVE_N_MIN       8'h03
`define RSVE_R_MAX       40
`define RSVE_R_MAX_V     6'h28
`define RSVE_R_MIN       6'h04
`define RSVE_FIELD_POLY  9'h11D
`define RSVE_GENSTART    8'h00
`define RSVE_ALPHA       8'h02
`define RSVE_ONE         8'h01
`define RSVE_N_RST       8'hFF
`define RSVE_R_RST       6'h10

`endif

// File: rtl/rsve_pkg.sv
// Types and field arithmetic shared by the variable Reed-Solomon encoder.
`include "rsve_defs.svh"

package rsve_pkg;

   typedef struct packed {
      logic                   check;
      logic                   last;
      logic [`RSVE_SYM_W-1:0] data;
   } rsve_sym_type;

   typedef struct packed {
      logic [`RSVE_N_W-1:0] n;
      logic [`RSVE_R_W-1:0] r;
   } rsve_cfg_type;

   typedef enum logic [1:0] {ST_GEN, ST_DATA, ST_CHECK} rsve_state_type;

   // Shift-and-add product reduced by the field polynomial.
   function automatic logic [`RSVE_SYM_W-1:0] rsve_gf_mul(
      input logic [`RSVE_SYM_W-1:0] a,
      input logic [`RSVE_SYM_W-1:0] b,
      input logic [`RSVE_SYM_W:0]   poly
   );
      logic [`RSVE_SYM_W-1:0] p;
      p = '0;
      for (int i = `RSVE_SYM_W - 1; i >= 0; i--) begin
         p = {p[`RSVE_SYM_W-2:0], 1'b0} ^ (p[`RSVE_SYM_W-1] ? poly[`RSVE_SYM_W-1:0] : '0);
         if (b[i]) begin
            p = p ^ a;
         end
      end
      return p;
   endfunction : rsve_gf_mul

   // A polynomial is usable only if alpha has the full order 2^m-1.
   function automatic logic rsve_field_ok(input logic [`RSVE_SYM_W:0] poly);
      logic [`RSVE_SYM_W-1:0] x;
      logic                   ok;
      x  = `RSVE_ONE;
      ok = poly[`RSVE_SYM_W];
      for (int i = 1; i < (1 << `RSVE_SYM_W); i++) begin
         x = rsve_gf_mul(x, `RSVE_ALPHA, poly);
         if ((x == `RSVE_ONE) != (i == (1 << `RSVE_SYM_W) - 1)) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction : rsve_field_ok

endpackage : rsve_pkg

// File: rtl/rsve_buf.sv
// Two-entry output buffer; the head entry drives the outputs straight from flops.
module rsve_buf (
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   // Filling side
   input  wire logic                  in_valid,
   input  wire rsve_pkg::rsve_sym_type in_sym,
   output logic                       in_ready,
   output logic                       in_ready_nx,
   // Draining side
   output logic                       out_valid,
   input  wire logic                  out_ready,
   output rsve_pkg::rsve_sym_type     out_sym
);
   import rsve_pkg::*;

   rsve_sym_type ent1_q;
   logic         v1_q;
   logic         v1_d;
   logic         pop;
   logic         push;

   assign pop         = out_valid & out_ready;
   assign push        = in_valid & in_ready;
   assign v1_d        = pop ? 1'b0 : (v1_q | (push & out_valid));
   assign in_ready    = ~v1_q;
   assign in_ready_nx = ~v1_d;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         out_valid <= 1'b0;
         v1_q      <= 1'b0;
         out_sym   <= '0;
         ent1_q    <= '0;
      end else begin
         v1_q <= v1_d;
         if (pop) begin
            out_valid <= v1_q | push;
            out_sym   <= v1_q ? ent1_q : in_sym;
         end else if (push && !out_valid) begin
            out_valid <= 1'b1;
            out_sym   <= in_sym;
         end else if (push) begin
            ent1_q <= in_sym;
         end
      end
   end

endmodule : rsve_buf

// File: rtl/rsve_top.sv
// Reed-Solomon systematic encoder with codeword length and check count set at run time.
// Functional notes
// - Each codeword leaves as its information symbols in order, then its check symbols.
// - All symbol arithmetic is done in GF(2^m) so every result is a field element.
// - The field polynomial is a build-time parameter; an invalid one is reported by an assertion but not refused.
// - A codeword never holds more than 2^m-1 symbols, 255 for 8-bit symbols.
// - The codeword length may be anything from 5 to 2^m-1 symbols.
// - The check count may be from 4 to one less than the length, at most 40.
// - The symbol width lies between 4 and 10 bits.
// - Built for the largest N and R, the current values are loaded by a write at run time.
// - Checks come from the product of (x - alpha^i) for i from the first root over R roots.
// - Symbols are produced at the symbol clock rate with no added pipeline delay.
`include "rsve_defs.svh"

module rsve_top #(
   parameter logic [`RSVE_SYM_W:0]   FIELD_POLY = `RSVE_FIELD_POLY,
   parameter logic [`RSVE_N_W-1:0]   GENSTART   = `RSVE_GENSTART
) (
   // Clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   nrst,
   // Information symbols from upstream
   input  wire logic                   s_valid,
   input  wire logic                   s_first,
   input  wire logic [`RSVE_SYM_W-1:0] s_data,
   output logic                        s_ready,
   // Codeword symbols to downstream
   output logic                        m_valid,
   input  wire logic                   m_ready,
   output rsve_pkg::rsve_sym_type      m_sym,
   // Run-time code setting
   input  wire logic                   cfg_wr,
   input  wire rsve_pkg::rsve_cfg_type cfg,
   output logic                        cfg_busy,
   output logic                        cfg_err
);
   import rsve_pkg::*;

   localparam int  W        = `RSVE_SYM_W;
   localparam int  RM       = `RSVE_R_MAX;
   localparam logic FIELD_OK = rsve_field_ok(FIELD_POLY);

   rsve_state_type         st_q;
   rsve_state_type         st_d;
   rsve_cfg_type           cur_q;
   logic [W-1:0]           gen_q [0:RM];
   logic [W-1:0]           gen_d [0:RM];
   logic [W-1:0]           rem_q [0:RM-1];
   logic [W-1:0]           rem_enc [0:RM-1];
   logic [W-1:0]           rem_sft [0:RM-1];
   logic [W-1:0]           rem_prod [0:RM-1];
   logic [W-1:0]           pow_q;
   logic [`RSVE_STEP_W-1:0] step_q;
   logic [`RSVE_N_W-1:0]   pos_q;
   logic [`RSVE_R_W-1:0]   chk_q;

   // Upstream hand-off and configuration decode.
   wire                    accept    = s_valid & s_ready;
   wire  [`RSVE_N_W-1:0]   k_len     = cur_q.n - {2'b00, cur_q.r};
   wire  [`RSVE_R_W-1:0]   r_top     = cur_q.r - 6'h01;
   wire  [`RSVE_N_W-1:0]   pos_nx    = s_first ? 8'h01 : pos_q + 8'h01;
   wire  [`RSVE_STEP_W-1:0] step_end = {1'b0, GENSTART} + {3'b000, cur_q.r} - 9'h001;
   wire                    cfg_range = (cfg.n >= `RSVE_N_MIN) && (cfg.r >= `RSVE_R_MIN)
                                       && (cfg.r <= `RSVE_R_MAX_V) && ({2'b00, cfg.r} < cfg.n);
   wire                    at_bound  = (st_q == ST_GEN) || (st_q == ST_DATA && pos_q == 8'h00);
   wire                    cfg_take  = cfg_wr & cfg_range & at_bound & ~accept;
   wire                    gen_step  = (st_q == ST_GEN) && (step_q >= {1'b0, GENSTART});
   wire                    gen_done  = (st_q == ST_GEN) && (step_q == step_end);
   wire  [W-1:0]           fb        = s_data ^ (s_first ? '0 : rem_q[r_top]);

   // Output buffer hand-off.
   logic                   b_rdy;
   logic                   b_rdy_nx;
   wire                    chk_push  = (st_q == ST_CHECK) && b_rdy;
   wire                    chk_last  = chk_q == r_top;
   wire                    b_push    = accept | chk_push;
   rsve_sym_type           b_sym;
   assign b_sym.check = chk_push;
   assign b_sym.last  = chk_push & chk_last;
   assign b_sym.data  = chk_push ? rem_q[r_top] : s_data;

   // Remainder division and generator growth, one multiplier per tap.
   genvar j;
   generate
      for (j = 0; j < RM; j++) begin : g_tap
         assign rem_prod[j] = rsve_gf_mul(fb, gen_q[j], FIELD_POLY);
         if (j == 0) begin : g_lo
            assign rem_enc[j] = rem_prod[j];
            assign rem_sft[j] = '0;
         end else begin : g_hi
            assign rem_enc[j] = (s_first ? '0 : rem_q[j-1]) ^ rem_prod[j];
            assign rem_sft[j] = rem_q[j-1];
         end
      end
      for (j = 0; j <= RM; j++) begin : g_gen
         if (j == 0) begin : g_lo
            assign gen_d[j] = rsve_gf_mul(pow_q, gen_q[j], FIELD_POLY);
         end else begin : g_hi
            assign gen_d[j] = gen_q[j-1] ^ rsve_gf_mul(pow_q, gen_q[j], FIELD_POLY);
         end
      end
   endgenerate

   // Next state.
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_GEN: begin
            if (!cfg_take && gen_done) begin
               st_d = ST_DATA;
            end
         end
         ST_DATA: begin
            if (cfg_take) begin
               st_d = ST_GEN;
            end else if (accept && pos_nx == k_len) begin
               st_d = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (chk_push && chk_last) begin
               st_d = ST_DATA;
            end
         end
         default: begin
            st_d = ST_GEN;
         end
      endcase
   end

   // Control registers. A write restarts the generator build, so a new code
   // only ever takes effect between codewords.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         st_q     <= ST_GEN;
         cur_q.n  <= `RSVE_N_RST;
         cur_q.r  <= `RSVE_R_RST;
         step_q   <= '0;
         pos_q    <= '0;
         chk_q    <= '0;
         pow_q    <= `RSVE_ONE;
         s_ready  <= 1'b0;
         cfg_busy <= 1'b1;
         cfg_err  <= 1'b0;
      end else begin
         st_q     <= st_d;
         s_ready  <= (st_d == ST_DATA) && b_rdy_nx;
         cfg_busy <= (st_d == ST_GEN);
         cfg_err  <= cfg_wr & ~cfg_take;
         if (cfg_take) begin
            cur_q  <= cfg;
            step_q <= '0;
            pow_q  <= `RSVE_ONE;
         end else if (st_q == ST_GEN) begin
            step_q <= step_q + 9'h001;
            pow_q  <= rsve_gf_mul(pow_q, `RSVE_ALPHA, FIELD_POLY);
         end
         if (cfg_take || st_q == ST_CHECK) begin
            pos_q <= '0;
         end else if (accept) begin
            pos_q <= pos_nx;
         end
         if (chk_push) begin
            chk_q <= chk_last ? '0 : chk_q + 6'h01;
         end
      end
   end

   // Generator coefficients and remainder taps.
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i <= RM; i++) begin
         if (!nrst || cfg_take) begin
            gen_q[i] <= (i == 0) ? `RSVE_ONE : '0;
         end else if (gen_step) begin
            gen_q[i] <= gen_d[i];
         end
      end
      for (int i = 0; i < RM; i++) begin
         if (!nrst || cfg_take || st_q == ST_GEN) begin
            rem_q[i] <= '0;
         end else if (accept) begin
            rem_q[i] <= rem_enc[i];
         end else if (chk_push) begin
            rem_q[i] <= rem_sft[i];
         end
      end
   end

   rsve_buf u_buf (
      .clk_sys     (clk_sys),
      .nrst        (nrst),
      .in_valid    (b_push),
      .in_sym      (b_sym),
      .in_ready    (b_rdy),
      .in_ready_nx (b_rdy_nx),
      .out_valid   (m_valid),
      .out_ready   (m_ready),
      .out_sym     (m_sym)
   );

   // Checks on the behaviour above.
   sequence seq_gen_exit;
      (st_q == ST_GEN) ##1 (st_q == ST_DATA);
   endsequence

   sequence seq_last_check;
      chk_push && chk_last;
   endsequence

   a_check_count: assert property (@(posedge clk_sys) disable iff (!nrst)
      seq_last_check |-> ##1 (st_q == ST_DATA && pos_q == 8'h00 && chk_q == 6'h00))
      else $error("check phase did not end after R symbols");
   a_gf_nonzero: assert property (@(posedge clk_sys) disable iff (!nrst)
      (accept && fb != '0 && gen_q[0] != '0) |-> rem_prod[0] != '0)
      else $error("field product of nonzero elements is zero");
   a_field_valid: assert property (@(posedge clk_sys) disable iff (!nrst)
      FIELD_OK)
      else $error("field polynomial is not primitive");
   a_len_limit: assert property (@(posedge clk_sys) disable iff (!nrst)
      (pos_q + {2'b00, chk_q}) < cur_q.n)
      else $error("codeword position passed its length");
   a_len_range: assert property (@(posedge clk_sys) disable iff (!nrst)
      cur_q.n >= `RSVE_N_MIN && cur_q.n <= `RSVE_N_MAX)
      else $error("codeword length out of range");
   a_chk_range: assert property (@(posedge clk_sys) disable iff (!nrst)
      cur_q.r >= `RSVE_R_MIN && cur_q.r <= `RSVE_R_MAX_V && {2'b00, cur_q.r} < cur_q.n)
      else $error("check count out of range");
   a_sym_width: assert property (@(posedge clk_sys) disable iff (!nrst)
      W >= `RSVE_SYM_W_MIN && W <= `RSVE_SYM_W_MAX)
      else $error("symbol width out of range");
   a_cfg_load: assert property (@(posedge clk_sys) disable iff (!nrst)
      cfg_take |=> (st_q == ST_GEN && cur_q == $past(cfg) && cfg_busy && !s_ready))
      else $error("accepted setting was not loaded");
   a_gen_monic: assert property (@(posedge clk_sys) disable iff (!nrst)
      seq_gen_exit |-> (gen_q[cur_q.r] == `RSVE_ONE && step_q == step_end + 9'h001))
      else $error("generator built with wrong degree");
   a_no_latency: assert property (@(posedge clk_sys) disable iff (!nrst)
      (accept && !m_valid) |=> (m_valid && m_sym.data == $past(s_data) && !m_sym.check))
      else $error("information symbol delayed");
   a_rem_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
      (accept && s_first && s_data == '0) |=> (rem_q[0] == '0 && rem_q[r_top] == '0))
      else $error("remainder not cleared at codeword start");

   // A stalled channel must see the head symbol stand still until it is taken.
   sequence seq_stall;
      m_valid && !m_ready;
   endsequence

   sequence seq_check_step;
      chk_push && !chk_last;
   endsequence

   a_busy_gen: assert property (@(posedge clk_sys) disable iff (!nrst)
      cfg_busy == (st_q == ST_GEN))
      else $error("busy flag does not follow generator build");
   a_busy_ready: assert property (@(posedge clk_sys) disable iff (!nrst)
      cfg_busy |-> !s_ready)
      else $error("symbols taken during generator build");
   a_ready_data: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_q != ST_DATA) |-> !s_ready)
      else $error("ready outside the information phase");
   a_ready_room: assert property (@(posedge clk_sys) disable iff (!nrst)
      s_ready |-> b_rdy)
      else $error("ready without buffer room");
   a_stall_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
      seq_stall |=> (m_valid && $stable(m_sym)))
      else $error("stalled symbol changed or vanished");
   a_last_check: assert property (@(posedge clk_sys) disable iff (!nrst)
      (m_valid && m_sym.last) |-> m_sym.check)
      else $error("last flag on an information symbol");
   a_info_flag: assert property (@(posedge clk_sys) disable iff (!nrst)
      accept |-> !b_sym.check)
      else $error("information symbol marked as check");
   a_pos_bound: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_q == ST_DATA) |-> (pos_q < k_len))
      else $error("information count passed its length");
   a_chk_step: assert property (@(posedge clk_sys) disable iff (!nrst)
      seq_check_step |=> (chk_q == $past(chk_q) + 6'h01))
      else $error("check counter did not advance");
   a_chk_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_q == ST_CHECK && !b_rdy) |=> $stable(chk_q))
      else $error("check counter moved while stalled");
   a_err_bad: assert property (@(posedge clk_sys) disable iff (!nrst)
      (cfg_wr && !cfg_range) |=> cfg_err)
      else $error("invalid setting not flagged");
   a_err_mid: assert property (@(posedge clk_sys) disable iff (!nrst)
      (cfg_wr && !at_bound) |=> (cfg_err && $stable(cur_q)))
      else $error("setting changed inside a codeword");
   a_gen_restart: assert property (@(posedge clk_sys) disable iff (!nrst)
      cfg_take |=> (gen_q[0] == `RSVE_ONE && step_q == '0 && pow_q == `RSVE_ONE))
      else $error("generator build did not restart");
   a_step_bound: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_q == ST_GEN) |-> (step_q <= step_end))
      else $error("generator build ran past its last root");
   a_rem_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
      (st_q == ST_GEN) |=> (rem_q[0] == '0))
      else $error("remainder not cleared during build");
   a_first_count: assert property (@(posedge clk_sys) disable iff (!nrst)
      (accept && s_first) |=> (pos_q == 8'h01))
      else $error("first symbol did not restart the count");

endmodule : rsve_top

// File: verif/rsve_sink.sv
// Downstream channel model that collects codeword symbols and can stall.
module rsve_sink (
   // Clock
   input  wire logic                   clk_sys,
   // Codeword stream from the encoder
   input  wire logic                   m_valid,
   input  wire rsve_pkg::rsve_sym_type m_sym,
   output logic                        m_ready,
   // Stall pattern: 0 never, 1 ready one cycle in four, 2 always stalled
   input  wire logic [1:0]             mode
);
   timeunit 1ns;
   timeprecision 1ps;
   import rsve_pkg::*;

   rsve_sym_type got[$];
   logic [1:0]   cnt_q;

   initial begin
      m_ready = 1'b0;
      cnt_q   = 2'h0;
   end

   // Ready moves just after the edge, like any registered channel input would.
   always @(posedge clk_sys) begin
      if (m_valid && m_ready) begin
         got.push_back(m_sym);
      end
      cnt_q   <= cnt_q + 2'h1;
      m_ready <= #1 (mode == 2'h0) || (mode == 2'h1 && cnt_q == 2'h0);
   end
endmodule : rsve_sink

// File: verif/tb_top.sv
// Self-checking bench for the variable Reed-Solomon encoder.
`include "rsve_defs.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rsve_pkg::*;

   logic         clk_sys    = 1'b0;
   logic         nrst       = 1'b0;
   logic         s_valid    = 1'b0;
   logic         s_first    = 1'b0;
   logic [7:0]   s_data     = 8'h00;
   logic         cfg_wr     = 1'b0;
   rsve_cfg_type cfg        = '0;
   logic [1:0]   mode       = 2'h0;
   logic         s_ready;
   logic         m_valid;
   logic         m_ready;
   logic         cfg_busy;
   logic         cfg_err;
   rsve_sym_type m_sym;
   int           n_mismatch = 0;
   int           n_compared = 0;
   logic [7:0]   gen[0:40];
   logic [7:0]   rem[0:39];
   rsve_sym_type exp_q[$];
   logic [8:0]   fp         = `RSVE_FIELD_POLY;

   always #4 clk_sys = ~clk_sys;

   rsve_top #(.FIELD_POLY(`RSVE_FIELD_POLY), .GENSTART(`RSVE_GENSTART)) dut_u (
      .clk_sys(clk_sys), .nrst(nrst), .s_valid(s_valid), .s_first(s_first),
      .s_data(s_data), .s_ready(s_ready), .m_valid(m_valid), .m_ready(m_ready),
      .m_sym(m_sym), .cfg_wr(cfg_wr), .cfg(cfg), .cfg_busy(cfg_busy), .cfg_err(cfg_err));

   rsve_sink sink_u (.clk_sys(clk_sys), .m_valid(m_valid), .m_sym(m_sym),
      .m_ready(m_ready), .mode(mode));

   // Field product, multiplicand doubled and reduced once per multiplier bit.
   function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      p = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) p = p ^ a;
         a = {a[6:0], 1'b0} ^ (a[7] ? fp[7:0] : 8'h00);
      end
      return p;
   endfunction : gmul

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude

   task automatic chk_sym(input rsve_sym_type got, input rsve_sym_type exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_sym

   task automatic chk_bit(input logic got, input logic exp);
      chk_sym({9'h000, got}, {9'h000, exp});
   endtask : chk_bit

   task automatic step;
      @(posedge clk_sys);
      #1;
   endtask : step

   task automatic wait_rdy;
      for (int i = 0; i < 400 && s_ready !== 1'b1; i++) step();
      if (s_ready !== 1'b1) begin
         n_mismatch++;
         conclude();
      end
   endtask : wait_rdy

   // Generator built as the product of (x + alpha^i) over r roots from the first root.
   task automatic build_gen(input int r);
      logic [7:0] pw;
      pw = 8'h01;
      for (int i = 0; i < `RSVE_GENSTART; i++) pw = gmul(pw, `RSVE_ALPHA);
      gen[0] = 8'h01;
      for (int i = 1; i <= 40; i++) gen[i] = 8'h00;
      for (int i = 0; i < r; i++) begin
         for (int j = i + 1; j > 0; j--) gen[j] = gen[j-1] ^ gmul(gen[j], pw);
         gen[0] = gmul(gen[0], pw);
         pw = gmul(pw, `RSVE_ALPHA);
      end
   endtask : build_gen

   task automatic run_cw(input int k, input int r, input logic [1:0] md, input int ofs);
      logic [7:0] d;
      logic [7:0] fb;
      build_gen(r);
      for (int i = 0; i < r; i++) rem[i] = 8'h00;
      sink_u.got.delete();
      mode = md;
      for (int i = 0; i < k; i++) begin
         d = 8'(i * 37 + ofs);
         fb = d ^ rem[r-1];
         for (int j = r - 1; j > 0; j--) rem[j] = rem[j-1] ^ gmul(fb, gen[j]);
         rem[0] = gmul(fb, gen[0]);
         exp_q.push_back({2'b00, d});
         s_valid = 1'b1;
         s_first = (i == 0);
         s_data = d;
         wait_rdy();
         step();
         if (i == 0 && md == 2'h0) begin
            chk_bit(m_valid, 1'b1);
            chk_sym(m_sym, {2'b00, d});
         end
      end
      s_valid = 1'b0;
      s_first = 1'b0;
      for (int i = r - 1; i >= 0; i--) exp_q.push_back({1'b1, i == 0, rem[i]});
      for (int i = 0; i < 3000 && sink_u.got.size() < k + r; i++) step();
      if (sink_u.got.size() < k + r) begin
         n_mismatch++;
         conclude();
      end
      while (exp_q.size() > 0) chk_sym(sink_u.got.pop_front(), exp_q.pop_front());
   endtask : run_cw

   task automatic set_cfg(input logic [7:0] n, input logic [5:0] r, input logic ok);
      cfg = {n, r};
      cfg_wr = 1'b1;
      step();
      cfg_wr = 1'b0;
      chk_bit(cfg_err, !ok);
      chk_bit(cfg_busy, ok);
      wait_rdy();
      chk_bit(cfg_busy, 1'b0);
   endtask : set_cfg

   // A stalled channel must stop intake at two words; a setting mid-codeword is refused.
   task automatic sc_fill;
      int taken;
      taken = 0;
      mode = 2'h2;
      sink_u.got.delete();
      s_valid = 1'b1;
      s_first = 1'b1;
      s_data = 8'h5A;
      for (int i = 0; i < 12; i++) begin
         if (s_ready === 1'b1) taken++;
         step();
         s_first = 1'b0;
      end
      s_valid = 1'b0;
      chk_bit(taken == 2, 1'b1);
      mode = 2'h0;
      repeat (4) step();
      chk_bit(sink_u.got.size() == 2, 1'b1);
      set_cfg(8'd204, 6'd16, 1'b0);
   endtask : sc_fill

   initial begin
      repeat (16) @(posedge clk_sys);
      #1;
      chk_bit(cfg_busy, 1'b1);
      chk_bit(s_ready, 1'b0);
      chk_bit(m_valid, 1'b0);
      nrst = 1'b1;
      wait_rdy();
      run_cw(239, 16, 2'h0, 1);
      set_cfg(8'd204, 6'd16, 1'b1);
      run_cw(188, 16, 2'h1, 3);
      set_cfg(8'd5, 6'd4, 1'b1);
      run_cw(1, 4, 2'h0, 4);
      run_cw(1, 4, 2'h0, 5);
      set_cfg(8'd50, 6'd40, 1'b1);
      run_cw(10, 40, 2'h1, 6);
      set_cfg(8'd5, 6'd3, 1'b0);
      set_cfg(8'd50, 6'd41, 1'b0);
      set_cfg(8'd8, 6'd8, 1'b0);
      set_cfg(8'd2, 6'd4, 1'b0);
      run_cw(10, 40, 2'h0, 7);
      sc_fill();
      run_cw(10, 40, 2'h0, 8);
      conclude();
   end

   // Cuts a hang short well inside the cycle budget.
   initial begin
      #400000;
      n_mismatch++;
      conclude();
   end
endmodule : tb_top
